// ### rtl/sfwl_pkg.sv
package sfwl_pkg;
  localparam int          WORD_W         = 14;
  localparam int          ADDR_W         = 16;
  localparam int          CMD_W          = 6;
  localparam int          CMD_LAST_BIT   = 5;
  localparam int          DATA_LAST_BIT  = 15;
  localparam logic [4:0]  CMD_LOAD_CFG   = 5'h00;
  localparam logic [4:0]  CMD_LOAD_DATA  = 5'h02;
  localparam logic [4:0]  CMD_READ       = 5'h04;
  localparam logic [4:0]  CMD_INC_ADDR   = 5'h06;
  localparam logic [4:0]  CMD_RESET_ADDR = 5'h16;
  localparam logic [4:0]  CMD_BEGIN_INT  = 5'h08;
  localparam logic [4:0]  CMD_BEGIN_EXT  = 5'h18;
  localparam logic [4:0]  CMD_END_EXT    = 5'h0a;
  localparam logic [4:0]  CMD_BULK_ERASE = 5'h09;
  localparam logic [4:0]  CMD_ROW_ERASE  = 5'h11;
  localparam logic [15:0] ADDR_RESET     = 16'h0000;
  localparam logic [15:0] CFG_BASE       = 16'h8000;
  localparam logic [15:0] PROG_TOP       = 16'h7fff;
  localparam logic [15:0] ADDR_TOP       = 16'hffff;
  localparam logic [15:0] CFG_LAST       = 16'h8008;
  localparam logic [3:0]  USER_ID_LAST   = 4'h3;
  localparam logic [3:0]  CFG_WORD1_IDX  = 4'h7;
  localparam logic [3:0]  CFG_WORD2_IDX  = 4'h8;
  localparam int          PROG_WORDS     = 16384;
  localparam int          CFG_WORDS      = 16;
  localparam int          LATCH_COUNT    = 32;
  localparam logic [13:0] ERASED_WORD    = 14'h3fff;
  localparam logic [13:0] CFG1_MASK      = 14'h3eff;
  localparam logic [13:0] CFG2_MASK_STD  = 14'h3e13;
  localparam logic [13:0] CFG2_MASK_LV   = 14'h3e03;
  localparam int          CP_BIT         = 7;
  localparam logic [1:0]  CSUM_PROG      = 2'h0;
  localparam logic [1:0]  CSUM_CFG1      = 2'h1;
  localparam logic [1:0]  CSUM_CFG2      = 2'h2;
  localparam logic [1:0]  CSUM_USER_ID   = 2'h3;
  localparam real         SYS_CLK_NS     = 25.0;
  localparam real         BULK_ERASE_MS  = 5.0;
  localparam real         ROW_ERASE_MS   = 2.5;
  localparam real         LINK_HALF_NS   = 200.0;
  localparam real         CMD_DELAY_US   = 1.0;
  localparam int BULK_ERASE_CYCLES = int'($ceil(BULK_ERASE_MS * 1.0e6 / SYS_CLK_NS));
  localparam int ROW_ERASE_CYCLES  = int'($ceil(ROW_ERASE_MS * 1.0e6 / SYS_CLK_NS));
  localparam int LINK_HALF_CYCLES  = int'($ceil(LINK_HALF_NS / SYS_CLK_NS));
  localparam int CMD_DELAY_CYCLES  = int'($ceil(CMD_DELAY_US * 1.0e3 / SYS_CLK_NS));
  localparam int TIMER_W           = 20;
endpackage

// ### rtl/sfwl_link_if.sv
interface sfwl_link_if;
  logic serialProgClock;
  logic progDataOut;
  logic progDataOe;
  logic devDataOut;
  logic devDataOe;
  logic serialProgData;

  // Line resolution with a weak pull-up when nobody drives
  assign serialProgData = devDataOe ? devDataOut : (progDataOe ? progDataOut : 1'b1);

  modport device(
    input  serialProgClock,
    input  serialProgData,
    output devDataOut,
    output devDataOe
  );

  modport programmer(
    output serialProgClock,
    output progDataOut,
    output progDataOe,
    input  serialProgData
  );
endinterface

// ### rtl/sfwl_device.sv
module sfwl_device #(
  parameter int LATCH_COUNT = sfwl_pkg::LATCH_COUNT
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  sfwl_link_if.device      link,
  output logic [15:0]      progAddressCounter,
  output logic             rowWritten
);
  localparam int LATCH_IDX_W = $clog2(LATCH_COUNT);

  typedef enum logic [2:0] {
    ST_CMD  = 3'b001,
    ST_DIN  = 3'b010,
    ST_DOUT = 3'b100
  } sfwl_dev_state_type;

  sfwl_dev_state_type state_q;
  sfwl_dev_state_type state_d;
  logic               clkSync1_q;
  logic               clkSync2_q;
  logic               clkPrev_q;
  logic               dataSync1_q;
  logic               dataSync2_q;
  logic [3:0]         bitCnt_q;
  logic [3:0]         bitCnt_d;
  logic [15:0]        shift_q;
  logic [15:0]        shift_d;
  logic [15:0]        addr_q;
  logic [15:0]        addr_d;
  logic [LATCH_COUNT-1:0] latchValid_q;
  logic [LATCH_COUNT-1:0] latchValid_d;
  logic               dataOut_q;
  logic               dataOut_d;
  logic               dataOe_q;
  logic               dataOe_d;
  logic               rowWritten_q;
  logic               rowWritten_d;
  logic               clkRise;
  logic               clkFall;
  logic [5:0]         cmdWord;
  logic [15:0]        dinWord;
  logic [13:0]        readWord;
  logic               latchWe;
  logic               commitEn;
  logic               commitToCfg;
  logic               bulkEn;
  logic               rowEraseEn;

  logic [13:0] progMem  [sfwl_pkg::PROG_WORDS];
  logic [13:0] cfgMem   [sfwl_pkg::CFG_WORDS];
  logic [13:0] latchMem [LATCH_COUNT];

  function automatic logic [15:0] rowAddr(input logic [15:0] a, input int i);
    logic [15:0] lowMask;
    lowMask = 16'(LATCH_COUNT - 1);
    rowAddr = (a & ~lowMask) | (16'(i) & lowMask);
  endfunction

  function automatic logic [15:0] nextAddr(input logic [15:0] a);
    if (a == sfwl_pkg::PROG_TOP) begin
      nextAddr = sfwl_pkg::ADDR_RESET;
    end else if (a == sfwl_pkg::ADDR_TOP) begin
      nextAddr = sfwl_pkg::CFG_BASE;
    end else begin
      nextAddr = a + 16'h0001;
    end
  endfunction

  // Both link pins pass two flip-flops first
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      clkSync1_q  <= 1'b0;
      clkSync2_q  <= 1'b0;
      clkPrev_q   <= 1'b0;
      dataSync1_q <= 1'b0;
      dataSync2_q <= 1'b0;
    end else begin
      clkSync1_q  <= link.serialProgClock;
      clkSync2_q  <= clkSync1_q;
      clkPrev_q   <= clkSync2_q;
      dataSync1_q <= link.serialProgData;
      dataSync2_q <= dataSync1_q;
    end
  end

  assign clkRise  = clkSync2_q & ~clkPrev_q;
  assign clkFall  = ~clkSync2_q & clkPrev_q;
  assign cmdWord  = {dataSync2_q, shift_q[15:11]};
  assign dinWord  = {dataSync2_q, shift_q[15:1]};
  assign readWord = addr_q[15] ? cfgMem[addr_q[3:0]] : progMem[addr_q[13:0]];

  always_comb begin
    state_d      = state_q;
    bitCnt_d     = bitCnt_q;
    shift_d      = shift_q;
    addr_d       = addr_q;
    latchValid_d = latchValid_q;
    dataOut_d    = dataOut_q;
    dataOe_d     = dataOe_q;
    rowWritten_d = 1'b0;
    latchWe      = 1'b0;
    commitEn     = 1'b0;
    commitToCfg  = 1'b0;
    bulkEn       = 1'b0;
    rowEraseEn   = 1'b0;
    case (state_q)
      ST_CMD: begin
        if (clkFall) begin
          shift_d  = dinWord;
          bitCnt_d = bitCnt_q + 4'h1;
          if (bitCnt_q == 4'(sfwl_pkg::CMD_LAST_BIT)) begin
            bitCnt_d = 4'h0;
            case (cmdWord[4:0])
              sfwl_pkg::CMD_LOAD_CFG: begin
                addr_d  = sfwl_pkg::CFG_BASE;
                state_d = ST_DIN;
              end
              sfwl_pkg::CMD_LOAD_DATA: begin
                state_d = ST_DIN;
              end
              sfwl_pkg::CMD_READ: begin
                shift_d = {1'b0, readWord, 1'b0};
                state_d = ST_DOUT;
              end
              sfwl_pkg::CMD_INC_ADDR: begin
                addr_d = nextAddr(addr_q);
              end
              sfwl_pkg::CMD_RESET_ADDR: begin
                addr_d = sfwl_pkg::ADDR_RESET;
              end
              sfwl_pkg::CMD_BEGIN_INT: begin
                commitEn     = 1'b1;
                commitToCfg  = addr_q[15];
                latchValid_d = '0;
                rowWritten_d = 1'b1;
              end
              sfwl_pkg::CMD_BEGIN_EXT: begin
                commitEn     = ~addr_q[15];
                latchValid_d = '0;
                rowWritten_d = ~addr_q[15];
              end
              sfwl_pkg::CMD_BULK_ERASE: begin
                bulkEn = 1'b1;
              end
              sfwl_pkg::CMD_ROW_ERASE: begin
                rowEraseEn = ~addr_q[15];
              end
              default: begin
              end
            endcase
          end
        end
      end
      ST_DIN: begin
        if (clkFall) begin
          shift_d  = dinWord;
          bitCnt_d = bitCnt_q + 4'h1;
          if (bitCnt_q == 4'(sfwl_pkg::DATA_LAST_BIT)) begin
            bitCnt_d = 4'h0;
            latchWe  = 1'b1;
            latchValid_d[addr_q[LATCH_IDX_W-1:0]] = 1'b1;
            state_d  = ST_CMD;
          end
        end
      end
      ST_DOUT: begin
        if (clkRise) begin
          dataOe_d  = 1'b1;
          dataOut_d = shift_q[0];
          shift_d   = {1'b0, shift_q[15:1]};
        end
        if (clkFall) begin
          bitCnt_d = bitCnt_q + 4'h1;
          if (bitCnt_q == 4'(sfwl_pkg::DATA_LAST_BIT)) begin
            bitCnt_d = 4'h0;
            dataOe_d = 1'b0;
            state_d  = ST_CMD;
          end
        end
      end
      default: begin
        state_d = ST_CMD;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q      <= ST_CMD;
      bitCnt_q     <= 4'h0;
      shift_q      <= 16'h0000;
      addr_q       <= sfwl_pkg::ADDR_RESET;
      latchValid_q <= '0;
      dataOut_q    <= 1'b0;
      dataOe_q     <= 1'b0;
      rowWritten_q <= 1'b0;
    end else begin
      state_q      <= state_d;
      bitCnt_q     <= bitCnt_d;
      shift_q      <= shift_d;
      addr_q       <= addr_d;
      latchValid_q <= latchValid_d;
      dataOut_q    <= dataOut_d;
      dataOe_q     <= dataOe_d;
      rowWritten_q <= rowWritten_d;
    end
  end

  // Storage arrays carry no reset
  always_ff @(posedge sys_clk) begin
    if (latchWe) begin
      latchMem[addr_q[LATCH_IDX_W-1:0]] <= dinWord[14:1];
    end
    if (commitEn) begin
      for (int i = 0; i < LATCH_COUNT; i++) begin
        if (latchValid_q[i]) begin
          // Row taken from address at commit time
          if (!commitToCfg) begin
            progMem[14'(rowAddr(addr_q, i))] <= latchMem[i];
          end else if (rowAddr(addr_q, i) <= sfwl_pkg::CFG_LAST) begin
            // Low bits index the small configuration array
            cfgMem[4'(rowAddr(addr_q, i))] <= latchMem[i];
          end
        end
      end
    end
    if (rowEraseEn) begin
      for (int i = 0; i < LATCH_COUNT; i++) begin
        progMem[14'(rowAddr(addr_q, i))] <= sfwl_pkg::ERASED_WORD;
      end
    end
    if (bulkEn && addr_q <= sfwl_pkg::CFG_LAST) begin
      for (int i = 0; i < sfwl_pkg::PROG_WORDS; i++) begin
        progMem[i] <= sfwl_pkg::ERASED_WORD;
      end
      cfgMem[sfwl_pkg::CFG_WORD1_IDX] <= sfwl_pkg::ERASED_WORD;
      cfgMem[sfwl_pkg::CFG_WORD2_IDX] <= sfwl_pkg::ERASED_WORD;
      if (addr_q[15]) begin
        for (int i = 0; i <= int'(sfwl_pkg::USER_ID_LAST); i++) begin
          cfgMem[i] <= sfwl_pkg::ERASED_WORD;
        end
      end
    end
  end

  assign link.devDataOut   = dataOut_q;
  assign link.devDataOe    = dataOe_q;
  assign progAddressCounter = addr_q;
  assign rowWritten         = rowWritten_q;
endmodule

// ### rtl/sfwl_programmer.sv
module sfwl_programmer #(
  parameter int BULK_ERASE_CYCLES = sfwl_pkg::BULK_ERASE_CYCLES,
  parameter int ROW_ERASE_CYCLES  = sfwl_pkg::ROW_ERASE_CYCLES
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  sfwl_link_if.programmer  link,
  input  wire logic        cmdStart,
  input  wire logic [5:0]  cmdCode,
  input  wire logic [13:0] cmdData,
  output logic             busy,
  output logic [13:0]      readData,
  output logic             readValid,
  input  wire logic        csumClear,
  input  wire logic        csumAdd,
  input  wire logic [1:0]  csumKind,
  input  wire logic [13:0] csumWord,
  input  wire logic        lowVoltagePart,
  output logic [15:0]      checksum
);
  localparam int TW = sfwl_pkg::TIMER_W;
  localparam logic [TW-1:0] HALF   = TW'(sfwl_pkg::LINK_HALF_CYCLES);
  localparam logic [TW-1:0] BITLEN = TW'(2 * sfwl_pkg::LINK_HALF_CYCLES);

  typedef enum logic [4:0] {
    H_IDLE = 5'b00001,
    H_CMD  = 5'b00010,
    H_GAP  = 5'b00100,
    H_DATA = 5'b01000,
    H_WAIT = 5'b10000
  } sfwl_host_state_type;

  sfwl_host_state_type state_q;
  sfwl_host_state_type state_d;
  logic [TW-1:0] timer_q;
  logic [TW-1:0] timer_d;
  logic [TW-1:0] waitLen_q;
  logic [TW-1:0] waitLen_d;
  logic [3:0]    bitCnt_q;
  logic [3:0]    bitCnt_d;
  logic [15:0]   shift_q;
  logic [15:0]   shift_d;
  logic [4:0]    cmd_q;
  logic [4:0]    cmd_d;
  logic [13:0]   wdata_q;
  logic [13:0]   wdata_d;
  logic          clk_q;
  logic          clk_d;
  logic          dOut_q;
  logic          dOut_d;
  logic          dOe_q;
  logic          dOe_d;
  logic          busy_q;
  logic          busy_d;
  logic [13:0]   rdData_q;
  logic [13:0]   rdData_d;
  logic          rdValid_q;
  logic          rdValid_d;
  logic          dSync1_q;
  logic          dSync2_q;
  logic [15:0]   progSum_q;
  logic [15:0]   progSum_d;
  logic [15:0]   cfgSum_q;
  logic [15:0]   cfgSum_d;
  logic [15:0]   idTerm_q;
  logic [15:0]   idTerm_d;
  logic          cpOff_q;
  logic          cpOff_d;
  logic [15:0]   csum_q;
  logic [15:0]   csum_d;
  logic          isData;
  logic          isRead;
  logic          bitEnd;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dSync1_q <= 1'b1;
      dSync2_q <= 1'b1;
    end else begin
      dSync1_q <= link.serialProgData;
      dSync2_q <= dSync1_q;
    end
  end

  assign isData = (cmd_q == sfwl_pkg::CMD_LOAD_CFG) || (cmd_q == sfwl_pkg::CMD_LOAD_DATA) || isRead;
  assign isRead = cmd_q == sfwl_pkg::CMD_READ;
  assign bitEnd = timer_q == BITLEN - TW'(1);

  always_comb begin
    state_d   = state_q;
    timer_d   = timer_q + TW'(1);
    waitLen_d = waitLen_q;
    bitCnt_d  = bitCnt_q;
    shift_d   = shift_q;
    cmd_d     = cmd_q;
    wdata_d   = wdata_q;
    clk_d     = clk_q;
    dOut_d    = dOut_q;
    dOe_d     = dOe_q;
    busy_d    = busy_q;
    rdData_d  = rdData_q;
    rdValid_d = 1'b0;
    case (state_q)
      H_IDLE: begin
        timer_d = '0;
        if (cmdStart) begin
          busy_d   = 1'b1;
          cmd_d    = cmdCode[4:0];
          wdata_d  = cmdData;
          shift_d  = {10'h000, cmdCode};
          bitCnt_d = 4'h0;
          state_d  = H_CMD;
        end
      end
      H_CMD, H_DATA: begin
        // Drive on rise, device samples on fall
        if (timer_q == '0) begin
          clk_d  = 1'b1;
          dOe_d  = !(state_q == H_DATA && isRead);
          dOut_d = shift_q[0];
        end
        if (timer_q == HALF - TW'(1)) begin
          shift_d = {dSync2_q, shift_q[15:1]};
        end
        if (timer_q == HALF) begin
          clk_d = 1'b0;
        end
        if (bitEnd) begin
          timer_d  = '0;
          bitCnt_d = bitCnt_q + 4'h1;
          if (state_q == H_CMD && bitCnt_q == 4'(sfwl_pkg::CMD_LAST_BIT)) begin
            bitCnt_d  = 4'h0;
            dOe_d     = 1'b0;
            waitLen_d = TW'(sfwl_pkg::CMD_DELAY_CYCLES);
            if (cmd_q == sfwl_pkg::CMD_BULK_ERASE) begin
              waitLen_d = TW'(BULK_ERASE_CYCLES);
            end else if (cmd_q == sfwl_pkg::CMD_ROW_ERASE) begin
              waitLen_d = TW'(ROW_ERASE_CYCLES);
            end
            state_d = isData ? H_GAP : H_WAIT;
            shift_d = {1'b0, wdata_q, 1'b0};
          end else if (state_q == H_DATA && bitCnt_q == 4'(sfwl_pkg::DATA_LAST_BIT)) begin
            bitCnt_d  = 4'h0;
            dOe_d     = 1'b0;
            rdData_d  = isRead ? shift_q[14:1] : rdData_q;
            rdValid_d = isRead;
            waitLen_d = TW'(sfwl_pkg::CMD_DELAY_CYCLES);
            state_d   = H_WAIT;
          end
        end
      end
      H_GAP: begin
        if (timer_q >= waitLen_q) begin
          timer_d = '0;
          state_d = H_DATA;
        end
      end
      H_WAIT: begin
        if (timer_q >= waitLen_q) begin
          busy_d  = 1'b0;
          state_d = H_IDLE;
        end
      end
      default: begin
        state_d = H_IDLE;
      end
    endcase
  end

  always_comb begin
    progSum_d = progSum_q;
    cfgSum_d  = cfgSum_q;
    idTerm_d  = idTerm_q;
    cpOff_d   = cpOff_q;
    if (csumClear) begin
      progSum_d = 16'h0000;
      cfgSum_d  = 16'h0000;
      idTerm_d  = 16'h0000;
      cpOff_d   = 1'b1;
    end else if (csumAdd) begin
      case (csumKind)
        sfwl_pkg::CSUM_PROG: begin
          progSum_d = progSum_q + {2'b00, csumWord};
        end
        sfwl_pkg::CSUM_CFG1: begin
          cfgSum_d = cfgSum_q + {2'b00, csumWord & sfwl_pkg::CFG1_MASK};
          cpOff_d  = csumWord[sfwl_pkg::CP_BIT];
        end
        sfwl_pkg::CSUM_CFG2: begin
          cfgSum_d = cfgSum_q + {2'b00, csumWord & (lowVoltagePart ? sfwl_pkg::CFG2_MASK_LV
                                                                    : sfwl_pkg::CFG2_MASK_STD)};
        end
        sfwl_pkg::CSUM_USER_ID: begin
          idTerm_d = {idTerm_q[11:0], csumWord[3:0]};
        end
        default: begin
        end
      endcase
    end
    csum_d = cpOff_d ? progSum_d + cfgSum_d : cfgSum_d + idTerm_d;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q   <= H_IDLE;
      timer_q   <= '0;
      waitLen_q <= '0;
      bitCnt_q  <= 4'h0;
      shift_q   <= 16'h0000;
      cmd_q     <= 5'h00;
      wdata_q   <= 14'h0000;
      clk_q     <= 1'b0;
      dOut_q    <= 1'b0;
      dOe_q     <= 1'b0;
      busy_q    <= 1'b0;
      rdData_q  <= 14'h0000;
      rdValid_q <= 1'b0;
      progSum_q <= 16'h0000;
      cfgSum_q  <= 16'h0000;
      idTerm_q  <= 16'h0000;
      cpOff_q   <= 1'b1;
      csum_q    <= 16'h0000;
    end else begin
      state_q   <= state_d;
      timer_q   <= timer_d;
      waitLen_q <= waitLen_d;
      bitCnt_q  <= bitCnt_d;
      shift_q   <= shift_d;
      cmd_q     <= cmd_d;
      wdata_q   <= wdata_d;
      clk_q     <= clk_d;
      dOut_q    <= dOut_d;
      dOe_q     <= dOe_d;
      busy_q    <= busy_d;
      rdData_q  <= rdData_d;
      rdValid_q <= rdValid_d;
      progSum_q <= progSum_d;
      cfgSum_q  <= cfgSum_d;
      idTerm_q  <= idTerm_d;
      cpOff_q   <= cpOff_d;
      csum_q    <= csum_d;
    end
  end

  assign link.serialProgClock = clk_q;
  assign link.progDataOut     = dOut_q;
  assign link.progDataOe      = dOe_q;
  assign busy                 = busy_q;
  assign readData             = rdData_q;
  assign readValid            = rdValid_q;
  assign checksum             = csum_q;
endmodule

// ### test/sfwl_asserts.sv
module sfwl_asserts (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic serialProgClock,
  input wire logic progDataOut,
  input wire logic progDataOe,
  input wire logic devDataOut,
  input wire logic devDataOe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       clkPrev_q;
  logic       clkPrev_d;
  logic [4:0] fallCnt_q;
  logic [4:0] fallCnt_d;
  // Clock falls seen while the device drives the line
  always_comb begin
    clkPrev_d = serialProgClock;
    fallCnt_d = fallCnt_q;
    if (!devDataOe) fallCnt_d = 5'h00;
    else if (clkPrev_q && !serialProgClock) fallCnt_d = fallCnt_q + 5'h01;
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      clkPrev_q <= 1'b0;
      fallCnt_q <= 5'h00;
    end else begin
      clkPrev_q <= clkPrev_d;
      fallCnt_q <= fallCnt_d;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_no_contention: assert property (!(progDataOe && devDataOe))
    else $error("both ends drive the data line");
  a_clk_high_width: assert property ($rose(serialProgClock) |-> serialProgClock [*8] ##1 !serialProgClock)
    else $error("link clock high phase not 8 cycles");
  a_clk_low_width: assert property ($fell(serialProgClock) |-> !serialProgClock [*8])
    else $error("link clock low phase too short");
  a_prog_data_hold: assert property (progDataOe && $past(progDataOe) && !$rose(serialProgClock)
    |-> $stable(progDataOut))
    else $error("programmer data changed inside a bit");
  a_prog_oe_rise: assert property ($rose(progDataOe) |-> $rose(serialProgClock))
    else $error("programmer started driving off a rising edge");
  a_dev_oe_high: assert property ($rose(devDataOe) |-> serialProgClock)
    else $error("device started driving in low phase");
  a_dev_data_high: assert property (devDataOe && $past(devDataOe) && $changed(devDataOut) |-> serialProgClock)
    else $error("device data changed in low phase");
  a_dev_release_count: assert property ($fell(devDataOe) |-> !serialProgClock && fallCnt_q == 5'h10)
    else $error("device released line not after 16 bits");
endmodule

// ### test/serial_flash_write_latch_checksum_tb.sv
module serial_flash_write_latch_checksum_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        cmdStart = 1'b0;
  logic [5:0]  cmdCode = 6'h00;
  logic [13:0] cmdData = 14'h0000;
  logic        csumClear = 1'b0;
  logic        csumAdd = 1'b0;
  logic [1:0]  csumKind = 2'h0;
  logic [13:0] csumWord = 14'h0000;
  logic        lowVoltagePart = 1'b0;
  logic        busy;
  logic [13:0] readData;
  logic        readValid;
  logic [15:0] checksum;
  logic [15:0] progAddressCounter;
  logic        rowWritten;
  int          fail_count = 0;
  int          n_tests = 0;
  int          cycles = 0;
  int          rowCnt = 0;
  int          rdCnt = 0;
  int          busyLen;
  sfwl_link_if link ();
  sfwl_device #(.LATCH_COUNT(4)) sfwl_device_i (.sys_clk(sys_clk), .rst_n(rst_n), .link(link.device),
    .progAddressCounter(progAddressCounter), .rowWritten(rowWritten));
  sfwl_programmer #(.BULK_ERASE_CYCLES(200), .ROW_ERASE_CYCLES(100)) sfwl_programmer_i (
    .sys_clk(sys_clk), .rst_n(rst_n), .link(link.programmer), .cmdStart(cmdStart), .cmdCode(cmdCode),
    .cmdData(cmdData), .busy(busy), .readData(readData), .readValid(readValid), .csumClear(csumClear),
    .csumAdd(csumAdd), .csumKind(csumKind), .csumWord(csumWord), .lowVoltagePart(lowVoltagePart),
    .checksum(checksum));
  sfwl_asserts sfwl_asserts_i (.sys_clk(sys_clk), .rst_n(rst_n), .serialProgClock(link.serialProgClock),
    .progDataOut(link.progDataOut), .progDataOe(link.progDataOe), .devDataOut(link.devDataOut),
    .devDataOe(link.devDataOe));
  always #12.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    if (rowWritten === 1'b1) rowCnt++;
    if (readValid === 1'b1) rdCnt++;
    cycles++;
    if (cycles == 60000) begin
      fail_count++;
      print_verdict();
    end
  end
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic send(input logic [5:0] code, input logic [13:0] data = 14'h0000);
    int n;
    @(posedge sys_clk);
    cmdCode <= code;
    cmdData <= data;
    cmdStart <= 1'b1;
    @(posedge sys_clk);
    cmdStart <= 1'b0;
    n = 0;
    @(negedge sys_clk);
    while (busy === 1'b1 && n < 2000) begin
      @(negedge sys_clk);
      n++;
    end
    busyLen = n;
    if (n >= 2000) check("busy end", 16'h0000, 16'h0001);
  endtask
  task automatic rd(input logic [13:0] exp);
    int r;
    r = rdCnt;
    send(6'h04);
    check("read word", {2'b00, exp}, {2'b00, readData});
    check("read strobes", 16'(r + 1), 16'(rdCnt));
  endtask
  task automatic seek(input int a);
    send(6'h16);
    repeat (a) send(6'h06);
  endtask
  task automatic t_erase;
    send(6'h00);
    send(6'h09);
    check("bulk erase wait", 16'h0001, 16'(busyLen >= 290));
    seek(0);
    rd(14'h3fff);
  endtask
  task automatic t_latch;
    int r;
    logic [13:0] exp [6] = '{14'h3fff, 14'h3fff, 14'h0a02, 14'h0a03, 14'h0a04, 14'h0a01};
    seek(2);
    for (int i = 0; i < 5; i++) begin
      send(6'h02, 14'h0a00 + 14'(i));
      if (i < 4) send(6'h06);
    end
    check("address", 16'h0006, progAddressCounter);
    rd(14'h3fff);
    r = rowCnt;
    send(6'h08);
    check("row writes", 16'(r + 1), 16'(rowCnt));
    seek(2);
    for (int i = 0; i < 6; i++) begin
      rd(exp[i]);
      if (i < 5) send(6'h06);
    end
    send(6'h11);
    check("row erase wait", 16'h0001, 16'(busyLen >= 190));
    rd(14'h3fff);
    send(6'h02, 14'h0bcd);
    r = rowCnt;
    send(6'h18);
    send(6'h0a);
    check("ext row writes", 16'(r + 1), 16'(rowCnt));
    rd(14'h0bcd);
  endtask
  task automatic t_cfg;
    int r;
    send(6'h00, 14'h1234);
    check("cfg address", 16'h8000, progAddressCounter);
    repeat (7) send(6'h06);
    send(6'h02, 14'h1234);
    r = rowCnt;
    send(6'h18);
    send(6'h0a);
    check("ext cfg writes", 16'(r), 16'(rowCnt));
    rd(14'h3fff);
    send(6'h00, 14'h0155);
    send(6'h08);
    check("cfg row writes", 16'(r + 1), 16'(rowCnt));
    rd(14'h0155);
  endtask
  task automatic t_sum(input logic lv, input logic [13:0] c1, input logic [13:0] id0, input logic [15:0] exp);
    logic [13:0] w [7] = '{14'h00aa, c1, 14'h3fff, id0, 14'h0008, 14'h0005, 14'h0008};
    @(posedge sys_clk);
    lowVoltagePart <= lv;
    csumClear <= 1'b1;
    @(posedge sys_clk);
    csumClear <= 1'b0;
    for (int i = 0; i < 7; i++) begin
      @(posedge sys_clk);
      csumKind <= (i < 3) ? 2'(i) : 2'h3;
      csumWord <= w[i];
      csumAdd <= 1'b1;
      @(posedge sys_clk);
      csumAdd <= 1'b0;
    end
    @(negedge sys_clk);
    check("checksum", exp, checksum);
  endtask
  initial begin
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_erase();
    t_latch();
    t_cfg();
    t_sum(1'b1, 14'h3f7f, 14'h000e, 16'h64da);
    t_sum(1'b0, 14'h3fff, 14'h0001, 16'h7dbc);
    print_verdict();
  end
endmodule
